// file: logic/dtc_pkg.sv
// constants, register map and types of the dual timer/counter block
package dtc_pkg;
   // ==========================================================
   // register byte addresses on the bus
   localparam logic [7:0] ADDR_CONTROL = 8'h88;
   localparam logic [7:0] ADDR_MODE    = 8'h89;
   localparam logic [7:0] ADDR_A_LOW   = 8'h8A;
   localparam logic [7:0] ADDR_B_LOW   = 8'h8B;
   localparam logic [7:0] ADDR_A_HIGH  = 8'h8C;
   localparam logic [7:0] ADDR_B_HIGH  = 8'h8D;
   localparam logic [7:0] ADDR_PINSEL  = 8'h93;
   // ==========================================================
   // control register bit positions
   localparam int CTL_TFB = 7;
   localparam int CTL_TRB = 6;
   localparam int CTL_TFA = 5;
   localparam int CTL_TRA = 4;
   localparam int CTL_IEB = 3;
   localparam int CTL_ITB = 2;
   localparam int CTL_IEA = 1;
   localparam int CTL_ITA = 0;
   // mode register bit positions
   localparam int MOD_GATEB = 7;
   localparam int MOD_SRCB  = 6;
   localparam int MOD_MB_HI = 5;
   localparam int MOD_MB_LO = 4;
   localparam int MOD_GATEA = 3;
   localparam int MOD_SRCA  = 2;
   localparam int MOD_MA_HI = 1;
   localparam int MOD_MA_LO = 0;
   // pin select bit positions
   localparam int PIN_OEB = 5;
   localparam int PIN_OEA = 4;
   // ==========================================================
   // reset values
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_MODE    = 8'h00;
   localparam logic [7:0] RST_COUNT   = 8'h00;
   localparam logic [7:0] RST_PINSEL  = 8'h05;
   // ==========================================================
   // counts
   localparam logic [4:0] OVF_DIV_A  = 5'h1F;  // toggle after 32 overflows
   localparam logic [4:0] PRESC_MAX  = 5'h1F;
   typedef enum logic [1:0] {
      DTC_M13    = 2'h0,
      DTC_M16    = 2'h1,
      DTC_MRLD   = 2'h2,
      DTC_MSPLIT = 2'h3
   } dtc_mode_t;
endpackage : dtc_pkg

// file: logic/dtc_timer.sv
// dual timer/counter with external interrupt pins, wishbone slave
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module dtc_timer (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // wishbone classic slave
   input  wire logic [7:0] wb_adr_i,
   input  wire logic [7:0] wb_dat_i,
   output logic      [7:0] wb_dat_o,
   input  wire logic       wb_we_i,
   input  wire logic       wb_sel_i,
   input  wire logic       wb_stb_i,
   input  wire logic       wb_cyc_i,
   output logic            wb_ack_o,
   output logic            wb_err_o,
   // pins
   input  wire logic       ext_irq_pin_a,
   input  wire logic       ext_irq_pin_b,
   input  wire logic       count_input_a,
   input  wire logic       count_input_b,
   // interrupt controller side
   input  wire logic       vector_ack_irq_a,
   input  wire logic       vector_ack_irq_b,
   input  wire logic       vector_ack_tmr_a,
   input  wire logic       vector_ack_tmr_b,
   output logic            irq_a_request,
   output logic            irq_b_request,
   output logic            timer_a_overflow_flag,
   output logic            timer_b_overflow_flag,
   // divided overflow outputs
   output logic            timer_a_divided_output,
   output logic            timer_a_divided_oe,
   output logic            timer_b_divided_output,
   output logic            timer_b_divided_oe
);
   // ==========================================================
   // pin synchronisers, three stages; change counts when 2 and 3 agree
   logic [2:0] syncIa_ff, syncIb_ff, syncCa_ff, syncCb_ff;
   logic       pinIa_ff, pinIb_ff, pinCa_ff, pinCb_ff;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         syncIa_ff <= 3'h7;
         syncIb_ff <= 3'h7;
         syncCa_ff <= 3'h7;
         syncCb_ff <= 3'h7;
      end else begin
         syncIa_ff <= {syncIa_ff[1:0], ext_irq_pin_a};
         syncIb_ff <= {syncIb_ff[1:0], ext_irq_pin_b};
         syncCa_ff <= {syncCa_ff[1:0], count_input_a};
         syncCb_ff <= {syncCb_ff[1:0], count_input_b};
      end
   end
   // filtered levels only move when stages two and three agree
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pinIa_ff <= 1'h1;
         pinIb_ff <= 1'h1;
         pinCa_ff <= 1'h1;
         pinCb_ff <= 1'h1;
      end else begin
         if (syncIa_ff[1] == syncIa_ff[2]) pinIa_ff <= syncIa_ff[2];
         if (syncIb_ff[1] == syncIb_ff[2]) pinIb_ff <= syncIb_ff[2];
         if (syncCa_ff[1] == syncCa_ff[2]) pinCa_ff <= syncCa_ff[2];
         if (syncCb_ff[1] == syncCb_ff[2]) pinCb_ff <= syncCb_ff[2];
      end
   end
   wire fallIa = pinIa_ff & (syncIa_ff[1] == syncIa_ff[2]) & ~syncIa_ff[2];
   wire fallIb = pinIb_ff & (syncIb_ff[1] == syncIb_ff[2]) & ~syncIb_ff[2];
   wire fallCa = pinCa_ff & (syncCa_ff[1] == syncCa_ff[2]) & ~syncCa_ff[2];
   wire fallCb = pinCb_ff & (syncCb_ff[1] == syncCb_ff[2]) & ~syncCb_ff[2];

   // ==========================================================
   // registers
   logic [7:0] ctl_ff, mode_ff, pinsel_ff;
   logic [7:0] aLow_ff, aHigh_ff, bLow_ff, bHigh_ff;
   logic [7:0] nxt_aLow, nxt_aHigh, nxt_bLow, nxt_bHigh;
   logic       half_ff;
   logic       ackDone_ff;

   // bus decode
   wire busReq  = wb_cyc_i & wb_stb_i & ~ackDone_ff;
   wire hitCtl  = wb_adr_i == dtc_pkg::ADDR_CONTROL;
   wire hitMode = wb_adr_i == dtc_pkg::ADDR_MODE;
   wire hitAL   = wb_adr_i == dtc_pkg::ADDR_A_LOW;
   wire hitBL   = wb_adr_i == dtc_pkg::ADDR_B_LOW;
   wire hitAH   = wb_adr_i == dtc_pkg::ADDR_A_HIGH;
   wire hitBH   = wb_adr_i == dtc_pkg::ADDR_B_HIGH;
   wire hitPin  = wb_adr_i == dtc_pkg::ADDR_PINSEL;
   wire mapped  = hitCtl | hitMode | hitAL | hitBL | hitAH | hitBH | hitPin;
   wire wrEn    = busReq & wb_we_i & wb_sel_i & mapped;

   // field decode
   wire runA  = ctl_ff[dtc_pkg::CTL_TRA];
   wire runB  = ctl_ff[dtc_pkg::CTL_TRB];
   dtc_pkg::dtc_mode_t modeA, modeB;
   assign modeA = dtc_pkg::dtc_mode_t'(mode_ff[dtc_pkg::MOD_MA_HI:dtc_pkg::MOD_MA_LO]);
   assign modeB = dtc_pkg::dtc_mode_t'(mode_ff[dtc_pkg::MOD_MB_HI:dtc_pkg::MOD_MB_LO]);

   // timer enables: run bit and optional gate on irq pin level
   wire enA = runA & (~mode_ff[dtc_pkg::MOD_GATEA] | pinIa_ff);
   wire enB = runB & (~mode_ff[dtc_pkg::MOD_GATEB] | pinIb_ff);
   // increment pulses: clock/2 tick or count pin falling edge
   wire tickA = mode_ff[dtc_pkg::MOD_SRCA] ? fallCa : half_ff;
   wire tickB = mode_ff[dtc_pkg::MOD_SRCB] ? fallCb : half_ff;
   wire incA  = enA & tickA;
   // split mode: high byte of A runs as a plain clock/2 timer on run B
   wire incAH = runB & half_ff;
   // timer B halts entirely in mode 11, split-mode A borrows its run bit
   wire incB  = enB & tickB & (modeB != dtc_pkg::DTC_MSPLIT);

   // ==========================================================
   // counting per unit
   logic ovfA, ovfB, ovfAH;
   always_comb begin
      nxt_aLow  = aLow_ff;
      nxt_aHigh = aHigh_ff;
      ovfA      = 1'b0;
      ovfAH     = 1'b0;
      case (modeA)
         dtc_pkg::DTC_M13: begin
            if (incA) begin
               // 5-bit prescaler in low byte, carry bumps high byte
               nxt_aLow = {3'h0, aLow_ff[4:0] + 5'h01};
               if (aLow_ff[4:0] == dtc_pkg::PRESC_MAX) begin
                  nxt_aHigh = aHigh_ff + 8'h01;
                  ovfA      = aHigh_ff == 8'hFF;
               end
            end
         end
         dtc_pkg::DTC_M16: begin
            if (incA) begin
               {nxt_aHigh, nxt_aLow} = {aHigh_ff, aLow_ff} + 16'h0001;
               ovfA = {aHigh_ff, aLow_ff} == 16'hFFFF;
            end
         end
         dtc_pkg::DTC_MRLD: begin
            if (incA) begin
               ovfA     = aLow_ff == 8'hFF;
               nxt_aLow = ovfA ? aHigh_ff : aLow_ff + 8'h01;
            end
         end
         dtc_pkg::DTC_MSPLIT: begin
            if (incA) begin
               nxt_aLow = aLow_ff + 8'h01;
               ovfA     = aLow_ff == 8'hFF;
            end
            if (incAH) begin
               nxt_aHigh = aHigh_ff + 8'h01;
               ovfAH     = aHigh_ff == 8'hFF;
            end
         end
         default: begin
            nxt_aLow  = aLow_ff;
            nxt_aHigh = aHigh_ff;
         end
      endcase
      // bus writes override counting in the same cycle
      if (wrEn && hitAL) nxt_aLow = wb_dat_i;
      if (wrEn && hitAH) nxt_aHigh = wb_dat_i;
   end

   always_comb begin
      nxt_bLow  = bLow_ff;
      nxt_bHigh = bHigh_ff;
      ovfB      = 1'b0;
      case (modeB)
         dtc_pkg::DTC_M13: begin
            if (incB) begin
               nxt_bLow = {3'h0, bLow_ff[4:0] + 5'h01};
               if (bLow_ff[4:0] == dtc_pkg::PRESC_MAX) begin
                  nxt_bHigh = bHigh_ff + 8'h01;
                  ovfB      = bHigh_ff == 8'hFF;
               end
            end
         end
         dtc_pkg::DTC_M16: begin
            if (incB) begin
               {nxt_bHigh, nxt_bLow} = {bHigh_ff, bLow_ff} + 16'h0001;
               ovfB = {bHigh_ff, bLow_ff} == 16'hFFFF;
            end
         end
         dtc_pkg::DTC_MRLD: begin
            if (incB) begin
               ovfB     = bLow_ff == 8'hFF;
               nxt_bLow = ovfB ? bHigh_ff : bLow_ff + 8'h01;
            end
         end
         default: begin
            nxt_bLow  = bLow_ff;   // mode 11: held
            nxt_bHigh = bHigh_ff;
         end
      endcase
      if (wrEn && hitBL) nxt_bLow = wb_dat_i;
      if (wrEn && hitBH) nxt_bHigh = wb_dat_i;
   end

   // overflow of B's flag comes from B or from split A high byte
   wire setTfA = ovfA;
   wire setTfB = ovfB | ovfAH;

   // ==========================================================
   // control register with hardware set/clear; hardware set wins
   logic [7:0] nxt_ctl;
   always_comb begin
      nxt_ctl = ctl_ff;
      if (wrEn && hitCtl) nxt_ctl = wb_dat_i;
      if (vector_ack_tmr_a) nxt_ctl[dtc_pkg::CTL_TFA] = 1'b0;
      if (vector_ack_tmr_b) nxt_ctl[dtc_pkg::CTL_TFB] = 1'b0;
      if (vector_ack_irq_a) nxt_ctl[dtc_pkg::CTL_IEA] = 1'b0;
      if (vector_ack_irq_b) nxt_ctl[dtc_pkg::CTL_IEB] = 1'b0;
      if (setTfA) nxt_ctl[dtc_pkg::CTL_TFA] = 1'b1;
      if (setTfB) nxt_ctl[dtc_pkg::CTL_TFB] = 1'b1;
      if (fallIa) nxt_ctl[dtc_pkg::CTL_IEA] = 1'b1;
      if (fallIb) nxt_ctl[dtc_pkg::CTL_IEB] = 1'b1;
   end

   // output A divider: toggle after 32 overflows gives rate/64
   logic [4:0] divA_ff;
   logic       outA_ff, outB_ff;

   // register file and counters
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctl_ff    <= dtc_pkg::RST_CONTROL;
         mode_ff   <= dtc_pkg::RST_MODE;
         pinsel_ff <= dtc_pkg::RST_PINSEL;
         aLow_ff   <= dtc_pkg::RST_COUNT;
         aHigh_ff  <= dtc_pkg::RST_COUNT;
         bLow_ff   <= dtc_pkg::RST_COUNT;
         bHigh_ff  <= dtc_pkg::RST_COUNT;
      end else begin
         ctl_ff    <= nxt_ctl;
         aLow_ff   <= nxt_aLow;
         aHigh_ff  <= nxt_aHigh;
         bLow_ff   <= nxt_bLow;
         bHigh_ff  <= nxt_bHigh;
         if (wrEn && hitMode) mode_ff <= wb_dat_i;
         if (wrEn && hitPin) pinsel_ff <= wb_dat_i;
      end
   end

   // clock/2 tick and divided outputs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         half_ff <= 1'b0;
         divA_ff <= 5'h00;
         outA_ff <= 1'b0;
         outB_ff <= 1'b0;
      end else begin
         half_ff <= ~half_ff;
         if (setTfA) begin
            divA_ff <= divA_ff + 5'h01;
            if (divA_ff == dtc_pkg::OVF_DIV_A) outA_ff <= ~outA_ff;
         end
         if (setTfB) outB_ff <= ~outB_ff;
      end
   end

   // ==========================================================
   // wishbone answer: ack one cycle after request, dropped next cycle
   logic [7:0] rdMux;
   assign rdMux = hitCtl  ? ctl_ff   :
                  hitMode ? mode_ff  :
                  hitAL   ? aLow_ff  :
                  hitBL   ? bLow_ff  :
                  hitAH   ? aHigh_ff :
                  hitBH   ? bHigh_ff :
                  hitPin  ? pinsel_ff : 8'h00;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wb_ack_o   <= 1'b0;
         wb_err_o   <= 1'b0;
         wb_dat_o   <= 8'h00;
         ackDone_ff <= 1'b0;
      end else begin
         wb_ack_o   <= busReq & mapped;
         wb_err_o   <= busReq & ~mapped;
         ackDone_ff <= busReq;
         wb_dat_o   <= busReq ? rdMux : 8'h00;
      end
   end

   // ==========================================================
   // outputs; request level mode uses low pin, edge mode the flag
   assign irq_a_request = ctl_ff[dtc_pkg::CTL_ITA] ? ctl_ff[dtc_pkg::CTL_IEA]
                                                   : ~pinIa_ff;
   assign irq_b_request = ctl_ff[dtc_pkg::CTL_ITB] ? ctl_ff[dtc_pkg::CTL_IEB]
                                                   : ~pinIb_ff;
   assign timer_a_overflow_flag  = ctl_ff[dtc_pkg::CTL_TFA];
   assign timer_b_overflow_flag  = ctl_ff[dtc_pkg::CTL_TFB];
   assign timer_a_divided_output = outA_ff;
   assign timer_a_divided_oe     = pinsel_ff[dtc_pkg::PIN_OEA];
   assign timer_b_divided_output = outB_ff;
   assign timer_b_divided_oe     = pinsel_ff[dtc_pkg::PIN_OEB];

   // ==========================================================
   // checks
   AST_RUN_A: assert property (@(posedge clk) disable iff (sys_rst)
      (!runA && !(wrEn && (hitAL || hitAH)) && modeA != dtc_pkg::DTC_MSPLIT)
      |=> $stable(aLow_ff) && $stable(aHigh_ff))
      else $error("timer A moved while stopped");
   AST_RUN_B: assert property (@(posedge clk) disable iff (sys_rst)
      (!runB && !(wrEn && (hitBL || hitBH))) |=> $stable(bLow_ff) && $stable(bHigh_ff))
      else $error("timer B moved while stopped");
   AST_EDGE_A: assert property (@(posedge clk) disable iff (sys_rst)
      fallIa |=> ctl_ff[dtc_pkg::CTL_IEA])
      else $error("edge flag A not set");
   AST_EDGE_B: assert property (@(posedge clk) disable iff (sys_rst)
      fallIb |=> ctl_ff[dtc_pkg::CTL_IEB])
      else $error("edge flag B not set");
   AST_OVF_A: assert property (@(posedge clk) disable iff (sys_rst)
      setTfA |=> timer_a_overflow_flag)
      else $error("overflow flag A not set");
   AST_OVF_B: assert property (@(posedge clk) disable iff (sys_rst)
      setTfB |=> timer_b_overflow_flag)
      else $error("overflow flag B not set");
   AST_TOG_B: assert property (@(posedge clk) disable iff (sys_rst)
      setTfB |=> outB_ff != $past(outB_ff))
      else $error("output B did not toggle");
   AST_WRAP16: assert property (@(posedge clk) disable iff (sys_rst)
      (incA && modeA == dtc_pkg::DTC_M16 && {aHigh_ff, aLow_ff} == 16'hFFFF
       && !(wrEn && (hitAL || hitAH))) |=> {aHigh_ff, aLow_ff} == 16'h0000)
      else $error("16-bit wrap wrong");
   // one-cycle answer; a stuck ack would let one request land twice
   sequence seqAckPulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   AST_ACK_ONE: assert property (@(posedge clk) disable iff (sys_rst)
      (busReq && mapped) |=> seqAckPulse)
      else $error("ack not a single pulse");
   AST_ERR_ONE: assert property (@(posedge clk) disable iff (sys_rst)
      (busReq && !mapped) |=> wb_err_o && !wb_ack_o)
      else $error("unmapped access not refused");
   AST_GATE_A: assert property (@(posedge clk) disable iff (sys_rst)
      (runA && mode_ff[dtc_pkg::MOD_GATEA] && !pinIa_ff && !(wrEn && hitAL))
      |=> $stable(aLow_ff))
      else $error("timer A counted with gate pin low");
   AST_CLR_TFA: assert property (@(posedge clk) disable iff (sys_rst)
      (vector_ack_tmr_a && !setTfA) |=> !timer_a_overflow_flag)
      else $error("overflow flag A not cleared on vector");
   AST_CLR_IEB: assert property (@(posedge clk) disable iff (sys_rst)
      (vector_ack_irq_b && !fallIb) |=> !ctl_ff[dtc_pkg::CTL_IEB])
      else $error("edge flag B not cleared on vector");
   AST_TOG_A: assert property (@(posedge clk) disable iff (sys_rst)
      (setTfA && divA_ff == dtc_pkg::OVF_DIV_A) |=> outA_ff != $past(outA_ff))
      else $error("output A did not toggle");
   AST_HALT_B: assert property (@(posedge clk) disable iff (sys_rst)
      (modeB == dtc_pkg::DTC_MSPLIT && !(wrEn && (hitBL || hitBH)))
      |=> $stable(bLow_ff) && $stable(bHigh_ff))
      else $error("timer B moved in stop mode");
endmodule : dtc_timer
`default_nettype wire

// file: testbench/dtc_pin_model.sv
// pin-side model: drives the interrupt and count pins of the timer block
`timescale 1ns/1ns
`default_nettype none
module dtc_pin_model (
   input  wire logic clk,
   output var  logic extIrqA,
   output var  logic extIrqB,
   output var  logic countInA,
   output var  logic countInB
);
   // ==========================================================
   // idle levels
   // pins rest high; the board holds them up when nothing pulls them down
   initial begin
      extIrqA = 1'b1;
      extIrqB = 1'b1;
      countInA = 1'b1;
      countInB = 1'b1;
   end
   // ==========================================================
   // pin tasks
   // level change lands just after a clock edge, like any board signal
   task automatic set_irq(input int t, input logic v);
      @(posedge clk);
      if (t == 0) extIrqA <= v;
      else extIrqB <= v;
   endtask : set_irq
   // n falling edges; 4 cycles per phase so the 3-flop sync sees each one
   task automatic pulse_count(input int t, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         if (t == 0) countInA <= 1'b0;
         else countInB <= 1'b0;
         repeat (4) @(posedge clk);
         if (t == 0) countInA <= 1'b1;
         else countInB <= 1'b1;
         repeat (4) @(posedge clk);
      end
   endtask : pulse_count
endmodule : dtc_pin_model
`default_nettype wire

// file: testbench/dtc_timer_tb.sv
// self-checking bench for the dual timer/counter block
`timescale 1ns/1ns
`default_nettype none
module dtc_timer_tb;
   logic       clk;
   logic       sysRst;
   logic [7:0] wbAdr;
   logic [7:0] wbDatI;
   logic [7:0] wbDatO;
   logic       wbWe;
   logic       wbSel;
   logic       wbStb;
   logic       wbCyc;
   logic       wbAck;
   logic       wbErr;
   logic       irqA, irqB, cntA, cntB;
   logic [3:0] vAck;
   logic       reqA, reqB, tfA, tfB, outA, oeA, outB, oeB;
   int         errCount;
   int         checkCount;
   int         cycCount;
   logic [7:0] d;
   logic       e;
   int         n;

   dtc_timer i_dtc_timer (.clk(clk), .sys_rst(sysRst), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_we_i(wbWe), .wb_sel_i(wbSel), .wb_stb_i(wbStb),
      .wb_cyc_i(wbCyc), .wb_ack_o(wbAck), .wb_err_o(wbErr), .ext_irq_pin_a(irqA),
      .ext_irq_pin_b(irqB), .count_input_a(cntA), .count_input_b(cntB),
      .vector_ack_irq_a(vAck[0]), .vector_ack_irq_b(vAck[1]), .vector_ack_tmr_a(vAck[2]),
      .vector_ack_tmr_b(vAck[3]), .irq_a_request(reqA), .irq_b_request(reqB),
      .timer_a_overflow_flag(tfA), .timer_b_overflow_flag(tfB),
      .timer_a_divided_output(outA), .timer_a_divided_oe(oeA),
      .timer_b_divided_output(outB), .timer_b_divided_oe(oeB));
   dtc_pin_model i_dtc_pin_model (.clk(clk), .extIrqA(irqA), .extIrqB(irqB),
      .countInA(cntA), .countInB(cntB));

   // ==========================================================
   // clock, verdict and hang guard
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic completeRun();
      $display("checks %0d mismatches %0d", checkCount, errCount);
      if (errCount == 0 && checkCount > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : completeRun
   // the whole sequence needs under a thousand cycles; 20000 means a hang
   always @(posedge clk) begin
      cycCount++;
      if (cycCount == 20000) begin
         errCount++;
         $display("[ERR] %0t timeout", $time);
         completeRun();
      end
   end
   // ==========================================================
   // bus and check helpers
   // classic cycle: hold everything until ack or err is seen high
   // no local limit; the cycle guard above ends a hang
   task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                      output logic [7:0] rd, output logic er);
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDatI <= wd;
      do begin
         @(posedge clk);
      end while (wbAck !== 1'b1 && wbErr !== 1'b1);
      rd = wbDatO;
      er = wbErr;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
      logic [7:0] x;
      logic y;
      bus(1'b1, adr, wd, x, y);
   endtask : wr
   task automatic rdr(input logic [7:0] adr, output logic [7:0] rd);
      logic y;
      bus(1'b0, adr, 8'h00, rd, y);
   endtask : rdr
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checkCount++;
      if (got !== exp) begin
         errCount++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic pick(input int s);
      case (s)
         0: return tfA;
         1: return tfB;
         2: return reqA;
         3: return reqB;
         4: return outA;
         default: return outB;
      endcase
   endfunction : pick
   // bounded wait for a watched output to reach a level
   task automatic waitLvl(input int s, input logic v, input int lim, output int k);
      k = 0;
      while (pick(s) !== v && k < lim) begin
         @(posedge clk);
         k++;
      end
      if (pick(s) !== v) begin
         errCount++;
         $display("[ERR] %0t wait for output %0d ran out", $time, s);
      end
   endtask : waitLvl
   task automatic pulseAck(input int i);
      @(posedge clk);
      vAck[i] <= 1'b1;
      @(posedge clk);
      vAck <= 4'h0;
      repeat (2) @(posedge clk);
   endtask : pulseAck
   // one overflow in mode m of timer t, then flag clear and stop
   task automatic runOvf(input int t, input int m);
      logic [7:0] lo;
      logic [7:0] hi;
      lo = t ? 8'h8B : 8'h8A;
      hi = t ? 8'h8D : 8'h8C;
      wr(8'h88, 8'h00);
      wr(8'h89, 8'(m << (4 * t)));
      wr(lo, (m == 0) ? 8'h1E : (m == 1) ? 8'hFC : 8'hFE);
      wr(hi, (m == 2) ? 8'h80 : 8'hFF);
      wr(8'h88, 8'(8'h10 << (2 * t)));
      waitLvl(t, 1'b1, 40, n);
      chk({7'h00, pick(t)}, 8'h01);
      rdr(hi, d);
      chk(d, (m == 2) ? 8'h80 : 8'h00);
      rdr(lo, d);
      if (m == 2) chk({7'h00, d[7]}, 8'h01);
      pulseAck(2 + t);
      chk({7'h00, pick(t)}, 8'h00);
      wr(8'h88, 8'h00);
      rdr(lo, hi);
      repeat (10) @(posedge clk);
      rdr(lo, d);
      chk(d, hi);
   endtask : runOvf

   // ==========================================================
   // main sequence
   initial begin
      sysRst = 1'b1;
      {wbAdr, wbDatI, wbWe, wbStb, wbCyc, vAck} = '0;
      wbSel = 1'b1;
      repeat (16) @(posedge clk);
      sysRst <= 1'b0;
      // reset values, byte read/write, unmapped place
      for (int i = 0; i < 6; i++) begin
         rdr(8'(8'h88 + i), d);
         chk(d, 8'h00);
      end
      rdr(8'h93, d);
      chk(d, 8'h05);
      for (int i = 2; i < 6; i++) begin
         wr(8'(8'h88 + i), 8'(8'hA5 ^ i));
         rdr(8'(8'h88 + i), d);
         chk(d, 8'(8'hA5 ^ i));
      end
      bus(1'b0, 8'h80, 8'h00, d, e);
      chk({7'h00, e}, 8'h01);
      // counting modes 00, 01 and 10 on both timers
      for (int t = 0; t < 2; t++) begin
         for (int m = 0; m < 3; m++) runOvf(t, m);
         // gate pin low holds the count, high lets it run
         wr(8'h89, 8'(8'h09 << (4 * t)));
         wr(8'(8'h8A + t), 8'h00);
         i_dtc_pin_model.set_irq(t, 1'b0);
         repeat (6) @(posedge clk);  // low level must pass the pin filter first
         wr(8'h88, 8'(8'h10 << (2 * t)));
         repeat (10) @(posedge clk);
         rdr(8'(8'h8A + t), d);
         chk(d, 8'h00);
         i_dtc_pin_model.set_irq(t, 1'b1);
         repeat (10) @(posedge clk);
         rdr(8'(8'h8A + t), d);
         chk({7'h00, d != 8'h00}, 8'h01);
         // count pin source: three falling edges, three counts
         wr(8'h88, 8'h00);
         wr(8'h89, 8'(8'h05 << (4 * t)));
         wr(8'(8'h8A + t), 8'h00);
         wr(8'h88, 8'(8'h10 << (2 * t)));
         i_dtc_pin_model.pulse_count(t, 3);
         repeat (8) @(posedge clk);
         rdr(8'(8'h8A + t), d);
         chk(d, 8'h03);
         // edge trigger: flag latches, vector clears it
         wr(8'h88, 8'(8'h01 << (2 * t)));
         i_dtc_pin_model.set_irq(t, 1'b0);
         repeat (8) @(posedge clk);
         chk({7'h00, pick(2 + t)}, 8'h01);
         i_dtc_pin_model.set_irq(t, 1'b1);
         rdr(8'h88, d);
         chk(d, 8'(8'h03 << (2 * t)));
         pulseAck(t);
         rdr(8'h88, d);
         chk(d, 8'(8'h01 << (2 * t)));
         // level trigger follows the pin
         wr(8'h88, 8'h00);
         i_dtc_pin_model.set_irq(t, 1'b0);
         repeat (8) @(posedge clk);
         chk({7'h00, pick(2 + t)}, 8'h01);
         i_dtc_pin_model.set_irq(t, 1'b1);
         repeat (8) @(posedge clk);
         chk({7'h00, pick(2 + t)}, 8'h00);
      end
      // split mode: high byte of A runs on B's run bit and flag, B itself stopped
      wr(8'h89, 8'h33);
      wr(8'h8C, 8'hFE);
      wr(8'h8B, 8'h55);
      wr(8'h88, 8'h40);
      waitLvl(1, 1'b1, 40, n);
      chk({6'h00, tfA, tfB}, 8'h01);
      rdr(8'h8B, d);
      chk(d, 8'h55);
      // divided outputs: overflow every tick, so A toggles each 64 cycles, B each 2
      wr(8'h88, 8'h00);
      wr(8'h93, 8'h35);
      chk({6'h00, oeB, oeA}, 8'h03);
      wr(8'h89, 8'h22);
      // low bytes at FF too, so the first reload comes at once
      wr(8'h8A, 8'hFF);
      wr(8'h8B, 8'hFF);
      wr(8'h8C, 8'hFF);
      wr(8'h8D, 8'hFF);
      wr(8'h88, 8'h50);
      for (int s = 4; s < 6; s++) begin
         waitLvl(s, ~pick(s), 300, n);
         waitLvl(s, ~pick(s), 300, n);
         chk(8'(n), (s == 4) ? 8'h40 : 8'h02);
      end
      wr(8'h93, 8'h05);
      chk({6'h00, oeB, oeA}, 8'h00);
      completeRun();
   end
endmodule : dtc_timer_tb
`default_nettype wire
